// *** rtl/pcs_pkg.sv ***
package pcs_pkg;

  localparam int unsigned PCS_PC_W     = 13;
  localparam int unsigned PCS_TGT_W    = 11;
  localparam int unsigned PCS_UPPER_W  = 5;
  localparam int unsigned PCS_STK_DEP  = 8;
  localparam int unsigned PCS_PAGE_MSB = 4;
  localparam int unsigned PCS_PAGE_LSB = 3;
  localparam int unsigned PCS_LATH_MSB = 4;

  // byte offsets on the register bus
  localparam logic [7:0] PCS_ADR_PCL   = 8'h00;
  localparam logic [7:0] PCS_ADR_LATH  = 8'h04;
  localparam logic [7:0] PCS_ADR_PCSTA = 8'h08;

  // values after reset, and the interrupt vector
  localparam logic [12:0] PCS_PC_RST   = 13'h0000;
  localparam logic [7:0]  PCS_LATH_RST = 8'h00;
  localparam logic [12:0] PCS_IRQ_VEC  = 13'h0004;

  typedef enum logic [3:0] {
    PCS_OP_NONE,
    PCS_OP_INC,
    PCS_OP_DIRECT_JUMP,
    PCS_OP_CALL,
    PCS_OP_IRQ,
    PCS_OP_RETURN,
    PCS_OP_LITERAL_EXIT,
    PCS_OP_INTERRUPT_EXIT,
    PCS_OP_PCL_WRITE,
    PCS_OP_LATH_WRITE
  } pcs_op_type;

  typedef struct packed {
    logic        valid;
    pcs_op_type  op;
    logic [10:0] target;
    logic [7:0]  data;
  } pcs_cmd_type;

endpackage

// *** rtl/pcs_program_counter.sv ***
`timescale 1ns/1ps
module pcs_program_counter
  import pcs_pkg::*;
#(
  parameter logic [12:0] IRQ_VECTOR = PCS_IRQ_VEC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // instruction decoder side
  input  wire pcs_cmd_type core_cmd_i,
  output logic      [12:0] program_counter_o,
  output logic      [7:0]  pc_high_latch_o
);

  typedef struct packed {
    logic [12:0] pc;
    logic [7:0]  lath;
    logic        ack;
    logic [31:0] rdat;
  } pcs_state_type;

  pcs_state_type st_r;
  pcs_state_type st_nxt;

  logic        push;
  logic        pop;
  logic [12:0] push_dat;
  logic [12:0] stk_top;
  logic        bus_req;
  logic        bus_wr;
  logic        core_go;

  function automatic logic [12:0] pcs_next(input logic [12:0] p);
    pcs_next = 13'(p + 13'h0001);
  endfunction

  // upper bits only ever come from the latch, so a low-byte add cannot carry
  function automatic logic [12:0] pcs_pcl_load(input logic [7:0] lath, input logic [7:0] lo);
    pcs_pcl_load = {lath[PCS_LATH_MSB:0], lo};
  endfunction

  assign core_go = core_cmd_i.valid;
  // core has priority; the bus waits as long as a core command is valid rather than race the decoder
  assign bus_req = wb_cyc_i && wb_stb_i && !st_r.ack && !core_go;
  assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

  assign push = core_go && (core_cmd_i.op == PCS_OP_CALL || core_cmd_i.op == PCS_OP_IRQ);
  assign pop  = core_go && (core_cmd_i.op == PCS_OP_RETURN ||
                            core_cmd_i.op == PCS_OP_LITERAL_EXIT ||
                            core_cmd_i.op == PCS_OP_INTERRUPT_EXIT);
  // call returns past itself; an interrupt resumes the instruction it preempted
  assign push_dat = (core_cmd_i.op == PCS_OP_CALL) ? pcs_next(st_r.pc) : st_r.pc;

  pcs_return_stack #(
    .DEPTH (PCS_STK_DEP),
    .WIDTH (PCS_PC_W)
  ) u_stack (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .push_i     (push),
    .pop_i      (pop),
    .push_dat_i (push_dat),
    .top_o      (stk_top)
  );

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = bus_req;
    if (bus_req) begin
      case (wb_adr_i)
        PCS_ADR_PCL:   st_nxt.rdat = {24'h000000, st_r.pc[7:0]};
        PCS_ADR_LATH:  st_nxt.rdat = {24'h000000, st_r.lath};
        PCS_ADR_PCSTA: st_nxt.rdat = {19'h00000, st_r.pc};
        default:       st_nxt.rdat = 32'h00000000;
      endcase
    end
    if (bus_wr) begin
      case (wb_adr_i)
        PCS_ADR_PCL:  st_nxt.pc   = pcs_pcl_load(st_r.lath, wb_dat_i[7:0]);
        PCS_ADR_LATH: st_nxt.lath = wb_dat_i[7:0];
        default:      st_nxt.lath = st_r.lath;
      endcase
    end
    if (core_go) begin
      case (core_cmd_i.op)
        PCS_OP_INC: st_nxt.pc = pcs_next(st_r.pc);
        PCS_OP_DIRECT_JUMP, PCS_OP_CALL: begin
          st_nxt.pc = {st_r.lath[PCS_PAGE_MSB:PCS_PAGE_LSB], core_cmd_i.target};
        end
        PCS_OP_IRQ: st_nxt.pc = IRQ_VECTOR;
        PCS_OP_RETURN, PCS_OP_LITERAL_EXIT, PCS_OP_INTERRUPT_EXIT: begin
          st_nxt.pc = stk_top;
        end
        PCS_OP_PCL_WRITE: begin
          st_nxt.pc = pcs_pcl_load(st_r.lath, core_cmd_i.data);
        end
        PCS_OP_LATH_WRITE: st_nxt.lath = core_cmd_i.data;
        default: st_nxt.pc = st_r.pc;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r.pc   <= PCS_PC_RST;
      st_r.lath <= PCS_LATH_RST;
      st_r.ack  <= 1'b0;
      st_r.rdat <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o          = st_r.rdat;
  assign wb_ack_o          = st_r.ack;
  assign program_counter_o = st_r.pc;
  assign pc_high_latch_o   = st_r.lath;

  // checks

  sequence call_taken_s;
    core_cmd_i.valid && core_cmd_i.op == PCS_OP_CALL;
  endsequence

  sequence ret_taken_s;
    core_cmd_i.valid && core_cmd_i.op == PCS_OP_RETURN;
  endsequence

  reset_clear_a: assert property (@(posedge clk_i)
    rst_i |=> program_counter_o == 13'h0000)
    else $error("program counter not cleared by reset");

  pcl_bus_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_wr && wb_adr_i == PCS_ADR_PCL
    |=> program_counter_o == {$past(st_r.lath[4:0]), $past(wb_dat_i[7:0])})
    else $error("bus write to low byte did not load counter");

  pcl_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && !wb_we_i && wb_adr_i == PCS_ADR_PCL
    |=> wb_ack_o && wb_dat_o == {24'h000000, $past(st_r.pc[7:0])})
    else $error("low byte read returned wrong value");

  pcl_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    core_go && core_cmd_i.op == PCS_OP_PCL_WRITE
    |=> program_counter_o[12:8] == $past(st_r.lath[4:0]))
    else $error("upper bits not taken from latch");

  no_carry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    core_go && core_cmd_i.op == PCS_OP_PCL_WRITE && core_cmd_i.data < st_r.pc[7:0]
    |=> program_counter_o[12:8] == $past(st_r.lath[4:0]))
    else $error("low byte rollover carried upward");

  jump_page_a: assert property (@(posedge clk_i) disable iff (rst_i)
    core_go && core_cmd_i.op == PCS_OP_DIRECT_JUMP
    |=> program_counter_o == {$past(st_r.lath[4:3]), $past(core_cmd_i.target)})
    else $error("direct jump address wrong");

  call_return_a: assert property (@(posedge clk_i) disable iff (rst_i)
    call_taken_s ##1 ret_taken_s
    |=> program_counter_o == 13'($past(st_r.pc, 2) + 13'h0001))
    else $error("return did not restore full address");

  irq_return_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (core_go && core_cmd_i.op == PCS_OP_IRQ) ##1
    (core_go && core_cmd_i.op == PCS_OP_INTERRUPT_EXIT)
    |=> program_counter_o == $past(st_r.pc, 2))
    else $error("interrupt exit did not resume");

  latch_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push || pop |=> $stable(pc_high_latch_o))
    else $error("stack action disturbed high latch");

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !core_go && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");

endmodule // pcs_program_counter

// *** rtl/pcs_return_stack.sv ***
`timescale 1ns/1ps
module pcs_return_stack
  import pcs_pkg::*;
#(
  parameter int unsigned DEPTH = PCS_STK_DEP,
  parameter int unsigned WIDTH = PCS_PC_W
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // stack actions
  input  wire logic             push_i,
  input  wire logic             pop_i,
  input  wire logic [WIDTH-1:0] push_dat_i,
  output logic      [WIDTH-1:0] top_o
);

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] ent;
    logic [PW-1:0]               ptr;
  } pcs_stk_type;

  pcs_stk_type st_r;
  pcs_stk_type st_nxt;

  function automatic logic [PW-1:0] pcs_wrap(input logic [PW-1:0] p, input logic up);
    pcs_wrap = up ? PW'(p + 1'b1) : PW'(p - 1'b1);
  endfunction

  // top is the last pushed slot; an empty stack just shows stale data
  assign top_o = st_r.ent[pcs_wrap(st_r.ptr, 1'b0)];

  always_comb begin
    st_nxt = st_r;
    if (push_i) begin
      st_nxt.ent[st_r.ptr] = push_dat_i;
      st_nxt.ptr           = pcs_wrap(st_r.ptr, 1'b1);
    end else if (pop_i) begin
      st_nxt.ptr = pcs_wrap(st_r.ptr, 1'b0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  stack_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push_i && st_r.ptr == PW'(DEPTH - 1) |=> st_r.ptr == '0)
    else $error("stack pointer did not wrap on push");

  empty_pop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pop_i && !push_i && st_r.ptr == '0 |=> st_r.ptr == PW'(DEPTH - 1))
    else $error("pop of empty stack did not wrap");

  push_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push_i |=> top_o == $past(push_dat_i))
    else $error("pushed value not on top");

endmodule // pcs_return_stack

// *** tb/pcs_core_model.sv ***
`timescale 1ns/1ps
module pcs_core_model
  import pcs_pkg::*;
(
  // clock
  input  wire logic  clk_i,
  // command to counter
  output pcs_cmd_type cmd_o
);
  initial cmd_o = '0;
  // valid drops after its taken edge, so the bus gets a free cycle between ops
  task automatic issue(input pcs_op_type op, input logic [10:0] tgt, input logic [7:0] dat);
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, op: op, target: tgt, data: dat};
    @(posedge clk_i);
    cmd_o.valid <= 1'b0;
  endtask
  // two ops on consecutive edges, no idle cycle between them
  task automatic issue2(input pcs_op_type a, input pcs_op_type b, input logic [10:0] tgt);
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, op: a, target: tgt, data: 8'h00};
    @(posedge clk_i);
    cmd_o.op <= b;
    @(posedge clk_i);
    cmd_o.valid <= 1'b0;
  endtask
endmodule // pcs_core_model

// *** tb/tb_program_counter_and_call_stack.sv ***
`timescale 1ns/1ps
module tb_program_counter_and_call_stack
  import pcs_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, ack;
  logic [7:0]  adr, lath;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [12:0] pc, exp_pc;
  logic [7:0]  lath_o;
  logic [12:0] stk [8];
  logic [2:0]  sp;
  pcs_cmd_type cmd;
  int          errors, n_checks;
  pcs_op_type  pops [3] = '{PCS_OP_RETURN, PCS_OP_LITERAL_EXIT, PCS_OP_INTERRUPT_EXIT};

  pcs_program_counter u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .core_cmd_i(cmd), .program_counter_o(pc), .pc_high_latch_o(lath_o));
  pcs_core_model u_core (.clk_i(clk_i), .cmd_o(cmd));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  // reference model of counter and circular stack
  task automatic step(input pcs_op_type o, input logic [10:0] t, input logic [7:0] d);
    u_core.issue(o, t, d);
    #1;
    if (o == PCS_OP_CALL || o == PCS_OP_IRQ) begin
      stk[sp] = (o == PCS_OP_CALL) ? exp_pc + 13'h1 : exp_pc;
      sp++;
    end
    if (o == PCS_OP_CALL || o == PCS_OP_DIRECT_JUMP) exp_pc = {lath[4:3], t};
    else if (o == PCS_OP_IRQ) exp_pc = PCS_IRQ_VEC;
    else if (o == PCS_OP_PCL_WRITE) exp_pc = {lath[4:0], d};
    else if (o == PCS_OP_INC) exp_pc = exp_pc + 13'h1;
    else if (o == PCS_OP_LATH_WRITE) lath = d;
    else if (o == PCS_OP_RETURN || o == PCS_OP_LITERAL_EXIT || o == PCS_OP_INTERRUPT_EXIT) begin
      sp--;
      exp_pc = stk[sp];
    end
    chk({19'h0, pc}, {19'h0, exp_pc});
    chk({24'h0, lath_o}, {24'h0, lath});
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #(100 * 3000);
    errors++;
    conclude;
  end

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    wdat = 32'h0; lath = 8'h00; exp_pc = 13'h0000; sp = 3'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({19'h0, pc}, 32'h0);
    bus(1'b0, PCS_ADR_PCL, 8'h00); chk(q, 32'h0);
    bus(1'b1, PCS_ADR_LATH, 8'h1f); lath = 8'h1f;
    bus(1'b0, PCS_ADR_LATH, 8'h00); chk(q, 32'h1f);
    step(PCS_OP_PCL_WRITE, 11'h000, 8'h34);
    bus(1'b0, PCS_ADR_PCSTA, 8'h00); chk(q, 32'h1f34);
    bus(1'b0, PCS_ADR_PCL, 8'h00); chk(q, 32'h34);
    bus(1'b1, PCS_ADR_PCL, 8'hff); chk({19'h0, pc}, 32'h1fff);
    bus(1'b1, PCS_ADR_LATH, 8'h0a); lath = 8'h0a;
    exp_pc = 13'h1fff;
    step(PCS_OP_PCL_WRITE, 11'h000, 8'h00);
    step(PCS_OP_DIRECT_JUMP, 11'h7ff, 8'h00);
    // ninth push lands on the first slot
    for (int i = 0; i < 9; i++) step(i == 4 ? PCS_OP_IRQ : PCS_OP_CALL, 11'h100 + 11'(i * 8), 8'h00);
    // page bit changes; returns must not depend on it
    bus(1'b1, PCS_ADR_LATH, 8'h00); lath = 8'h00;
    for (int i = 0; i < 9; i++) step(pops[i % 3], 11'h000, 8'h00);
    step(PCS_OP_LATH_WRITE, 11'h000, 8'h18);
    step(PCS_OP_DIRECT_JUMP, 11'h123, 8'h00);
    step(PCS_OP_INC, 11'h000, 8'h00);
    step(PCS_OP_NONE, 11'h000, 8'h00);
    u_core.issue2(PCS_OP_CALL, PCS_OP_RETURN, 11'h055);
    #1;
    exp_pc = exp_pc + 13'h1;
    chk({19'h0, pc}, {19'h0, exp_pc});
    u_core.issue2(PCS_OP_IRQ, PCS_OP_INTERRUPT_EXIT, 11'h000);
    #1;
    chk({19'h0, pc}, {19'h0, exp_pc});
    bus(1'b0, 8'h0c, 8'h00); chk(q, 32'h0);
    bus(1'b1, PCS_ADR_PCSTA, 8'h55); chk({19'h0, pc}, {19'h0, exp_pc});
    @(posedge clk_i) rst_i <= 1'b1;
    @(posedge clk_i) rst_i <= 1'b0;
    #1;
    chk({19'h0, pc}, 32'h0);
    chk({24'h0, lath_o}, 32'h0);
    conclude;
  end
endmodule // tb_program_counter_and_call_stack
